// ### inc/sys_ctrl_pkg.sv
// Constants, register map and carrier types of the system clock and reset control
// What this block does
// - Machine cycle lasts timing-select code plus one oscillator clocks, one to eight.
// - Timing select resets to 001 (register 10h); rewrites take effect at once.
// - Clock-output field drives port 3 bit 4: pin, clock, clock/2, clock/4.
// - Hardware reset held 25, 200, 100, 50, 16, 8 or 4 ms by configuration.
// - Key writes 55h, AAh, 5Ah in order unlock the soft-reset trigger.
// - Trigger register ignores writes until the key sequence completes.
// - Unlocked, writing FFh resets the chip; 00h to FEh only relocks the trigger.
// - Software reset request is ORed with the hardware reset sources.
// - Trigger register returns to 00h when the software reset ends.
// - Power-on reset sets cause bit 0 until software clears it.
// - Low-voltage reset sets cause bit 1 until software clears it.
// - Software reset sets cause bit 2 until software clears it.
// - Watchdog reset sets cause bit 3 until software clears it.
// - Internal low-voltage source sets cause bit 6 until software clears it.
// - Initialization stage after reset runs from the undivided 16 MHz clock.
// - Normal clock is the oscillator divided to 16, 8, 4, 2 or 1 MHz.
package sys_ctrl_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_CLOCK_TIMING_CONTROL = 10'h08e;
  localparam logic [9:0] IDX_RESET_CAUSE_STATUS   = 10'h0a1;
  localparam logic [9:0] IDX_SOFT_RESET_TRIGGER   = 10'h0e7;
  localparam logic [9:0] IDX_ACCESS_KEY           = 10'h0f7;
  localparam logic [9:0] IDX_BOOT_CONFIG          = 10'h100;
  localparam logic [9:0] IDX_EVENT_STATUS         = 10'h101;
  localparam logic [9:0] IDX_EVENT_MASK           = 10'h102;

  localparam logic [7:0] RST_CLOCK_TIMING_CONTROL = 8'h10;
  localparam logic [7:0] RST_BYTE_ZERO            = 8'h00;
  localparam logic [7:0] CTC_WRITE_MASK           = 8'h73;
  localparam int         CTC_TIMING_LSB           = 4;
  localparam int         CTC_PINSEL_LSB           = 0;
  localparam logic [7:0] CAUSE_WRITE_MASK         = 8'h4f;
  localparam int         CAUSE_POWER_ON           = 0;
  localparam int         CAUSE_LOW_VOLTAGE        = 1;
  localparam int         CAUSE_SOFTWARE           = 2;
  localparam int         CAUSE_WATCHDOG           = 3;
  localparam int         CAUSE_INTERNAL_LV        = 6;

  localparam logic [7:0] KEY_FIRST                = 8'h55;
  localparam logic [7:0] KEY_SECOND               = 8'haa;
  localparam logic [7:0] KEY_THIRD                = 8'h5a;
  localparam logic [7:0] TRIGGER_FIRE             = 8'hff;

  // Boot configuration: bits 2:0 reset time select, bits 6:4 clock select
  localparam int         CFG_HOLD_LSB             = 0;
  localparam int         CFG_CLK_LSB              = 4;
  localparam logic [7:0] RST_BOOT_CONFIG          = 8'h00;
  localparam logic [7:0] CFG_WRITE_MASK           = 8'h77;

  // Event bits: reset done, unlock granted, key sequence broken
  localparam int         EVT_RESET_DONE           = 0;
  localparam int         EVT_UNLOCKED             = 1;
  localparam int         EVT_KEY_ERROR            = 2;
  localparam logic [7:0] EVT_WRITE_MASK           = 8'h07;

  localparam int unsigned CLK_KHZ   = 125000;
  localparam int unsigned HOLD_25_MS  = 25;
  localparam int unsigned HOLD_200_MS = 200;
  localparam int unsigned HOLD_100_MS = 100;
  localparam int unsigned HOLD_50_MS  = 50;
  localparam int unsigned HOLD_16_MS  = 16;
  localparam int unsigned HOLD_8_MS   = 8;
  localparam int unsigned HOLD_4_MS   = 4;
  localparam int unsigned HOLD_25_CYCLES  = HOLD_25_MS * CLK_KHZ;
  localparam int unsigned HOLD_200_CYCLES = HOLD_200_MS * CLK_KHZ;
  localparam int unsigned HOLD_100_CYCLES = HOLD_100_MS * CLK_KHZ;
  localparam int unsigned HOLD_50_CYCLES  = HOLD_50_MS * CLK_KHZ;
  localparam int unsigned HOLD_16_CYCLES  = HOLD_16_MS * CLK_KHZ;
  localparam int unsigned HOLD_8_CYCLES   = HOLD_8_MS * CLK_KHZ;
  localparam int unsigned HOLD_4_CYCLES   = HOLD_4_MS * CLK_KHZ;
  localparam int          HOLD_W          = 25;
  localparam logic [7:0]  INIT_CYCLES     = 8'h10;

  typedef enum logic [1:0] {
    SEQ_HOLD = 2'b00,
    SEQ_INIT = 2'b01,
    SEQ_RUN  = 2'b11
  } seq_state_t;

  typedef enum logic [1:0] {
    KEY_IDLE  = 2'b00,
    KEY_GOT1  = 2'b01,
    KEY_GOT2  = 2'b11,
    KEY_OPEN  = 2'b10
  } key_state_t;

  typedef struct packed {
    logic internal_low_voltage;
    logic watchdog;
    logic low_voltage;
    logic power_on;
  } reset_sources_t;

  typedef struct packed {
    logic out;
    logic oe_n;
  } pin_drive_t;
endpackage

// ### rtl/system_clock_reset_control.sv
// System clock, reset sequencing, software reset and reset cause logic
`timescale 1ns/1ns
module system_clock_reset_control #(
  parameter int unsigned HOLD_25_CYC  = sys_ctrl_pkg::HOLD_25_CYCLES,
  parameter int unsigned HOLD_200_CYC = sys_ctrl_pkg::HOLD_200_CYCLES,
  parameter int unsigned HOLD_100_CYC = sys_ctrl_pkg::HOLD_100_CYCLES,
  parameter int unsigned HOLD_50_CYC  = sys_ctrl_pkg::HOLD_50_CYCLES,
  parameter int unsigned HOLD_16_CYC  = sys_ctrl_pkg::HOLD_16_CYCLES,
  parameter int unsigned HOLD_8_CYC   = sys_ctrl_pkg::HOLD_8_CYCLES,
  parameter int unsigned HOLD_4_CYC   = sys_ctrl_pkg::HOLD_4_CYCLES
) (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [11:0]                  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic      [31:0]                  prdata,
  output logic                              pready,
  output logic                              pslverr,
  input  wire sys_ctrl_pkg::reset_sources_t reset_sources,
  input  wire sys_ctrl_pkg::pin_drive_t     port3_bit4_gpio,
  output sys_ctrl_pkg::pin_drive_t          port3_bit4_pin,
  output logic                              chip_reset_n,
  output logic                              osc_tick,
  output logic                              machine_cycle_tick,
  output logic                              irq
);
  import sys_ctrl_pkg::*;

  seq_state_t       seq_state;
  key_state_t       key_state;
  logic [HOLD_W-1:0] hold_count;
  logic [7:0]       init_count;
  logic [7:0]       clock_timing_control;
  logic [7:0]       reset_cause_status;
  logic [7:0]       soft_reset_trigger;
  logic [7:0]       access_key;
  logic [7:0]       boot_config;
  logic [7:0]       event_status;
  logic [7:0]       event_mask;
  logic             power_on_seen;
  logic [4:0]       osc_count;
  logic [2:0]       mc_count;
  logic [1:0]       co_count;
  logic             co_level;

  logic       wr_en;
  logic       setup;
  logic [9:0] idx;
  logic [7:0] wbyte;
  logic       soft_fire;
  logic       hw_reset;
  logic       any_reset;
  logic       hold_done;
  logic       key_error;
  logic       key_grant;
  logic [7:0] cause_set;
  logic [7:0] evt_set;
  logic       mapped;
  logic [7:0] rbyte;
  logic [4:0] osc_div;

  function automatic logic [HOLD_W-1:0] hold_cycles(input logic [2:0] sel);
    int unsigned c;
    case (sel)
      3'h1:    c = HOLD_200_CYC;
      3'h2:    c = HOLD_100_CYC;
      3'h3:    c = HOLD_50_CYC;
      3'h4:    c = HOLD_16_CYC;
      3'h5:    c = HOLD_8_CYC;
      3'h6:    c = HOLD_4_CYC;
      default: c = HOLD_25_CYC;
    endcase
    // Never below one cycle of hold
    if (c == 0)
    begin
      c = 1;
    end
    return HOLD_W'(c - 1);
  endfunction

  localparam logic [HOLD_W-1:0] HOLD_AT_RESET = hold_cycles(3'h0);

  // Divide ratio of the oscillator, 16 MHz base down to 1 MHz
  function automatic logic [4:0] clock_divisor(input logic [2:0] sel);
    logic [4:0] d;
    case (sel)
      3'h1:    d = 5'h02;
      3'h2:    d = 5'h04;
      3'h3:    d = 5'h08;
      3'h4:    d = 5'h10;
      default: d = 5'h01;
    endcase
    return d;
  endfunction

  assign setup  = psel & ~penable;
  assign wr_en  = psel & penable & pwrite & (seq_state != SEQ_HOLD);
  assign idx    = paddr[11:2];
  assign wbyte  = pwdata[7:0];
  assign pready = 1'b1;

  assign soft_fire = wr_en && (idx == IDX_SOFT_RESET_TRIGGER) && (key_state == KEY_OPEN)
                     && (wbyte == TRIGGER_FIRE);
  assign hw_reset  = reset_sources.power_on | reset_sources.low_voltage
                     | reset_sources.watchdog | reset_sources.internal_low_voltage;
  assign any_reset = hw_reset | soft_fire;
  assign hold_done = (seq_state == SEQ_HOLD) && (hold_count == '0) && !any_reset;

  // Reset sequencer: hold, then a short initialization stage, then run
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seq_state  <= SEQ_HOLD;
      hold_count <= HOLD_AT_RESET;
      init_count <= '0;
    end
    else
    begin
      case (seq_state)
        SEQ_HOLD:
        begin
          if (any_reset)
          begin
            hold_count <= hold_cycles(boot_config[CFG_HOLD_LSB +: 3]);
          end
          else if (hold_count != '0)
          begin
            hold_count <= hold_count - 1'b1;
          end
          else
          begin
            seq_state  <= SEQ_INIT;
            init_count <= INIT_CYCLES;
          end
        end
        SEQ_INIT:
        begin
          if (any_reset)
          begin
            seq_state  <= SEQ_HOLD;
            hold_count <= hold_cycles(boot_config[CFG_HOLD_LSB +: 3]);
          end
          else if (init_count == '0)
          begin
            seq_state <= SEQ_RUN;
          end
          else
          begin
            init_count <= init_count - 1'b1;
          end
        end
        SEQ_RUN:
        begin
          if (any_reset)
          begin
            seq_state  <= SEQ_HOLD;
            hold_count <= hold_cycles(boot_config[CFG_HOLD_LSB +: 3]);
          end
        end
        default:
        begin
          seq_state  <= SEQ_HOLD;
          hold_count <= hold_cycles(boot_config[CFG_HOLD_LSB +: 3]);
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chip_reset_n <= 1'b0;
    end
    else
    begin
      chip_reset_n <= (seq_state != SEQ_HOLD) && !any_reset;
    end
  end

  // Power-on is seen on the first edge after release of presetn
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      power_on_seen <= 1'b0;
    end
    else
    begin
      power_on_seen <= 1'b1;
    end
  end

  always_comb
  begin
    cause_set = '0;
    cause_set[CAUSE_POWER_ON]    = !power_on_seen | reset_sources.power_on;
    cause_set[CAUSE_LOW_VOLTAGE] = reset_sources.low_voltage;
    cause_set[CAUSE_SOFTWARE]    = soft_fire;
    cause_set[CAUSE_WATCHDOG]    = reset_sources.watchdog;
    cause_set[CAUSE_INTERNAL_LV] = reset_sources.internal_low_voltage;
  end

  // Cause flags survive the chip reset they record; only presetn or a software write clears them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reset_cause_status <= RST_BYTE_ZERO;
    end
    else if (psel && penable && pwrite && idx == IDX_RESET_CAUSE_STATUS)
    begin
      reset_cause_status <= ((reset_cause_status & wbyte) | cause_set) & CAUSE_WRITE_MASK;
    end
    else
    begin
      reset_cause_status <= reset_cause_status | cause_set;
    end
  end

  // Unlock sequence; the chip reset puts it back to idle
  always_comb
  begin
    key_error = 1'b0;
    key_grant = 1'b0;
    if (wr_en && idx == IDX_ACCESS_KEY)
    begin
      case (key_state)
        KEY_GOT1: key_error = (wbyte != KEY_SECOND);
        KEY_GOT2:
        begin
          key_error = (wbyte != KEY_THIRD);
          key_grant = (wbyte == KEY_THIRD);
        end
        default:  key_error = (wbyte != KEY_FIRST);
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      key_state  <= KEY_IDLE;
      access_key <= RST_BYTE_ZERO;
    end
    else if (seq_state == SEQ_HOLD)
    begin
      key_state  <= KEY_IDLE;
      access_key <= RST_BYTE_ZERO;
    end
    else if (wr_en && idx == IDX_ACCESS_KEY)
    begin
      access_key <= wbyte;
      case (key_state)
        KEY_GOT1: key_state <= (wbyte == KEY_SECOND) ? KEY_GOT2
                             : (wbyte == KEY_FIRST) ? KEY_GOT1 : KEY_IDLE;
        KEY_GOT2: key_state <= (wbyte == KEY_THIRD) ? KEY_OPEN
                             : (wbyte == KEY_FIRST) ? KEY_GOT1 : KEY_IDLE;
        default:  key_state <= (wbyte == KEY_FIRST) ? KEY_GOT1 : KEY_IDLE;
      endcase
    end
    else if (wr_en && idx == IDX_SOFT_RESET_TRIGGER && key_state == KEY_OPEN)
    begin
      // One trigger write uses up the permission
      key_state <= KEY_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      soft_reset_trigger <= RST_BYTE_ZERO;
    end
    else if (soft_fire)
    begin
      soft_reset_trigger <= TRIGGER_FIRE;
    end
    else if (hold_done)
    begin
      soft_reset_trigger <= RST_BYTE_ZERO;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      clock_timing_control <= RST_CLOCK_TIMING_CONTROL;
    end
    else if (seq_state == SEQ_HOLD)
    begin
      clock_timing_control <= RST_CLOCK_TIMING_CONTROL;
    end
    else if (wr_en && idx == IDX_CLOCK_TIMING_CONTROL)
    begin
      clock_timing_control <= wbyte & CTC_WRITE_MASK;
    end
  end

  // Stands for the writer-programmed options, so chip reset keeps it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      boot_config <= RST_BOOT_CONFIG;
    end
    else if (wr_en && idx == IDX_BOOT_CONFIG)
    begin
      boot_config <= wbyte & CFG_WRITE_MASK;
    end
  end

  always_comb
  begin
    evt_set                 = '0;
    evt_set[EVT_RESET_DONE] = hold_done;
    evt_set[EVT_UNLOCKED]   = key_grant;
    evt_set[EVT_KEY_ERROR]  = key_error;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      event_status <= RST_BYTE_ZERO;
      event_mask   <= RST_BYTE_ZERO;
    end
    else
    begin
      if (psel && penable && pwrite && idx == IDX_EVENT_STATUS)
      begin
        event_status <= (event_status & ~wbyte) | evt_set;
      end
      else
      begin
        event_status <= event_status | evt_set;
      end
      if (psel && penable && pwrite && idx == IDX_EVENT_MASK)
      begin
        event_mask <= wbyte & EVT_WRITE_MASK;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= |(event_status & event_mask);
    end
  end

  assign osc_div = (seq_state == SEQ_RUN) ? clock_divisor(boot_config[CFG_CLK_LSB +: 3])
                                          : 5'h01;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_count <= '0;
      osc_tick  <= 1'b0;
    end
    else if (seq_state == SEQ_HOLD)
    begin
      osc_count <= '0;
      osc_tick  <= 1'b0;
    end
    else if (osc_count >= osc_div - 5'h01)
    begin
      osc_count <= '0;
      osc_tick  <= 1'b1;
    end
    else
    begin
      osc_count <= osc_count + 5'h01;
      osc_tick  <= 1'b0;
    end
  end

  // Machine cycle length
  // The compare against the live field lets a shorter setting take effect at once
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mc_count           <= '0;
      machine_cycle_tick <= 1'b0;
    end
    else if (seq_state == SEQ_HOLD)
    begin
      mc_count           <= '0;
      machine_cycle_tick <= 1'b0;
    end
    else if (!osc_tick)
    begin
      machine_cycle_tick <= 1'b0;
    end
    else if (mc_count >= clock_timing_control[CTC_TIMING_LSB +: 3])
    begin
      mc_count           <= '0;
      machine_cycle_tick <= 1'b1;
    end
    else
    begin
      mc_count           <= mc_count + 3'h1;
      machine_cycle_tick <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      co_count <= '0;
      co_level <= 1'b0;
    end
    else if (seq_state == SEQ_HOLD)
    begin
      co_count <= '0;
      co_level <= 1'b0;
    end
    else if (osc_tick)
    begin
      co_count <= co_count + 2'h1;
      case (clock_timing_control[CTC_PINSEL_LSB +: 2])
        2'h1:    co_level <= ~co_level;
        2'h2:    co_level <= co_level ^ co_count[0];
        2'h3:    co_level <= co_level ^ (co_count == 2'h3);
        default: co_level <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port3_bit4_pin <= '{out: 1'b0, oe_n: 1'b1};
    end
    else if (seq_state == SEQ_HOLD)
    begin
      port3_bit4_pin <= '{out: 1'b0, oe_n: 1'b1};
    end
    else if (clock_timing_control[CTC_PINSEL_LSB +: 2] == 2'h0)
    begin
      port3_bit4_pin <= port3_bit4_gpio;
    end
    else
    begin
      port3_bit4_pin <= '{out: co_level, oe_n: 1'b0};
    end
  end

  always_comb
  begin
    mapped = 1'b1;
    case (idx)
      IDX_CLOCK_TIMING_CONTROL: rbyte = clock_timing_control;
      IDX_RESET_CAUSE_STATUS:   rbyte = reset_cause_status;
      IDX_SOFT_RESET_TRIGGER:   rbyte = soft_reset_trigger;
      IDX_ACCESS_KEY:           rbyte = access_key;
      IDX_BOOT_CONFIG:          rbyte = boot_config;
      IDX_EVENT_STATUS:         rbyte = event_status;
      IDX_EVENT_MASK:           rbyte = event_mask;
      default:
      begin
        rbyte  = RST_BYTE_ZERO;
        mapped = 1'b0;
      end
    endcase
  end

  // Read data and error are captured in the setup cycle so they come from flops
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
    else if (setup)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rbyte};
      pslverr <= !mapped;
    end
  end
endmodule

// ### dv/system_clock_reset_control_props.sv
// Concurrent checks on the system clock and reset control ports
`timescale 1ns/1ns
module scrc_props #(
  parameter int unsigned HOLD_4_CYC   = 28,
  parameter int unsigned HOLD_200_CYC = 72
) (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pwrite,
  input wire logic [11:0]                  paddr,
  input wire logic [31:0]                  pwdata,
  input wire logic                         pslverr,
  input wire sys_ctrl_pkg::reset_sources_t reset_sources,
  input wire logic                         chip_reset_n,
  input wire logic                         osc_tick,
  input wire logic                         irq
);
  import sys_ctrl_pkg::*;
  logic [31:0] low_cycles;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Restarted by a source pulse, since a pulse reloads the hold
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_cycles <= 32'h0;
    else if (chip_reset_n || reset_sources != 4'h0)
      low_cycles <= 32'h0;
    else
      low_cycles <= low_cycles + 32'h1;
  end

  function automatic logic mapped(logic [9:0] i);
    return i inside {IDX_CLOCK_TIMING_CONTROL, IDX_RESET_CAUSE_STATUS, IDX_SOFT_RESET_TRIGGER,
                     IDX_ACCESS_KEY, IDX_BOOT_CONFIG, IDX_EVENT_STATUS, IDX_EVENT_MASK};
  endfunction

  sequence key_wr(logic [7:0] v);
    psel && penable && pwrite && paddr[11:2] == IDX_ACCESS_KEY && pwdata[7:0] == v;
  endsequence
  sequence key_bad;
    psel && penable && pwrite && paddr[11:2] == IDX_ACCESS_KEY && pwdata[7:0] != KEY_THIRD;
  endsequence
  sequence fire_wr;
    psel && penable && pwrite && paddr[11:2] == IDX_SOFT_RESET_TRIGGER
      && pwdata[7:0] == TRIGGER_FIRE && chip_reset_n && reset_sources == 4'h0;
  endsequence
  sequence unlock_seq;
    key_wr(KEY_FIRST) ##3 key_wr(KEY_SECOND) ##3 key_wr(KEY_THIRD);
  endsequence

  a_soft_fire: assert property (unlock_seq ##3 fire_wr |=> !chip_reset_n)
    else $error("trigger after unlock did not reset the chip");
  a_key_order: assert property (
    key_wr(KEY_FIRST) ##3 key_wr(KEY_SECOND) ##3 key_bad ##3 fire_wr |=> chip_reset_n)
    else $error("broken key order still fired a reset");
  a_fire_only_ff: assert property (psel && penable && pwrite
    && paddr[11:2] == IDX_SOFT_RESET_TRIGGER && pwdata[7:0] != TRIGGER_FIRE
    && chip_reset_n && reset_sources == 4'h0 |=> chip_reset_n)
    else $error("non-fire trigger value reset the chip");
  a_source_reset: assert property (reset_sources != 4'h0 |=> !chip_reset_n)
    else $error("hardware source did not hold the chip in reset");
  a_hold_span: assert property ($rose(chip_reset_n) |->
    low_cycles + 32'h2 >= HOLD_4_CYC && low_cycles <= HOLD_200_CYC + 2)
    else $error("reset hold length outside configured range");
  a_init_fast: assert property ($rose(chip_reset_n) |-> ##[2:3] osc_tick [*4])
    else $error("start-up stage not on undivided clock");
  a_err_decode: assert property (psel && !penable |=>
    pslverr == !mapped($past(paddr[11:2])))
    else $error("slave error does not match address decode");
  a_mask_irq: assert property (psel && penable && pwrite && paddr[11:2] == IDX_EVENT_MASK
    && pwdata[7:0] == 8'h00 |-> ##[1:3] !irq)
    else $error("interrupt stayed high with all events masked");
endmodule

bind system_clock_reset_control scrc_props #(
  .HOLD_4_CYC  (HOLD_4_CYC),
  .HOLD_200_CYC(HOLD_200_CYC)
) u_props (
  .pclk         (pclk),
  .presetn      (presetn),
  .psel         (psel),
  .penable      (penable),
  .pwrite       (pwrite),
  .paddr        (paddr),
  .pwdata       (pwdata),
  .pslverr      (pslverr),
  .reset_sources(reset_sources),
  .chip_reset_n (chip_reset_n),
  .osc_tick     (osc_tick),
  .irq          (irq)
);

// ### dv/tb_top.sv
// Register-level testbench for the system clock and reset control
`timescale 1ns/1ns
module tb_top;
  import sys_ctrl_pkg::*;
  logic           pclk = 1'b0, presetn = 1'b0;
  logic           psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]    paddr = 12'h000;
  logic [31:0]    pwdata = 32'h0, prdata, rdat, rerr;
  logic           pready, pslverr, chip_reset_n, osc_tick, machine_cycle_tick, irq;
  reset_sources_t reset_sources = 4'h0;
  pin_drive_t     port3_bit4_gpio = 2'b00, port3_bit4_pin;
  int             n_fail = 0, samples_checked = 0, g, sel;
  localparam int  HOLD_T[7] = '{40, 72, 56, 48, 36, 32, 28};
  int             cause_bit[4] = '{0, 1, 3, 6};

  always #4 pclk = ~pclk;

  // Short holds keep the run small; expectations come from HOLD_T
  system_clock_reset_control #(.HOLD_25_CYC(HOLD_T[0]), .HOLD_200_CYC(HOLD_T[1]),
    .HOLD_100_CYC(HOLD_T[2]), .HOLD_50_CYC(HOLD_T[3]), .HOLD_16_CYC(HOLD_T[4]),
    .HOLD_8_CYC(HOLD_T[5]), .HOLD_4_CYC(HOLD_T[6])) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_sources(reset_sources), .port3_bit4_gpio(port3_bit4_gpio),
    .port3_bit4_pin(port3_bit4_pin), .chip_reset_n(chip_reset_n), .osc_tick(osc_tick),
    .machine_cycle_tick(machine_cycle_tick), .irq(irq));

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic xfer(input logic [9:0] idx, input logic wr, input logic [7:0] d);
    int t;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {idx, 2'b00}; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    t = 0;
    do
    begin
      @(posedge pclk);
      t++;
    end
    while (pready !== 1'b1 && t < 50);
    if (t >= 50)
    begin
      n_fail++;
      stop_test();
    end
    rdat = prdata;
    rerr = {31'h0, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [9:0] idx, input logic [7:0] e);
    xfer(idx, 1'b0, 8'h00);
    chk(rdat, {24'h0, e});
  endtask

  task automatic unlock();
    xfer(IDX_ACCESS_KEY, 1'b1, KEY_FIRST);
    xfer(IDX_ACCESS_KEY, 1'b1, KEY_SECOND);
    xfer(IDX_ACCESS_KEY, 1'b1, KEY_THIRD);
  endtask

  // Counts edges until the chip leaves reset
  task automatic wait_up(output int n);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (chip_reset_n !== 1'b1 && n < 2000);
    if (n >= 2000)
    begin
      n_fail++;
      stop_test();
    end
  endtask

  // Gap between the 2nd and 3rd event; the first may straddle a mode change
  task automatic gap(input int w, output int g);
    int   k, t, first;
    logic p, e;
    k = 0;
    first = 0;
    g = 0;
    p = port3_bit4_pin.out;
    for (t = 0; t < 400 && k < 3; t++)
    begin
      @(posedge pclk);
      e = (w == 0) ? osc_tick : (w == 1) ? machine_cycle_tick : (port3_bit4_pin.out !== p);
      p = port3_bit4_pin.out;
      if (e === 1'b1)
      begin
        k++;
        g = t - first;
        first = t;
      end
    end
    if (k < 3)
    begin
      n_fail++;
      stop_test();
    end
  endtask

  task automatic chip_up();
    repeat (2) @(posedge pclk);
    chk({31'h0, chip_reset_n}, 32'h1);
  endtask

  initial
  begin
    repeat (100000) @(posedge pclk);
    n_fail++;
    stop_test();
  end

  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    wait_up(g);
    rdchk(IDX_CLOCK_TIMING_CONTROL, 8'h10);
    rdchk(IDX_RESET_CAUSE_STATUS, 8'h01);
    rdchk(IDX_SOFT_RESET_TRIGGER, 8'h00);
    rdchk(IDX_ACCESS_KEY, 8'h00);
    xfer(10'h3ff, 1'b0, 8'h00);
    chk(rerr, 32'h1);
    xfer(10'h3ff, 1'b1, 8'h5a);
    chk(rerr, 32'h1);
    unlock();
    xfer(IDX_SOFT_RESET_TRIGGER, 1'b1, 8'hfe);
    chip_up();
    xfer(IDX_SOFT_RESET_TRIGGER, 1'b1, TRIGGER_FIRE);
    chip_up();
    rdchk(IDX_SOFT_RESET_TRIGGER, 8'h00);
    xfer(IDX_ACCESS_KEY, 1'b1, KEY_FIRST);
    xfer(IDX_ACCESS_KEY, 1'b1, KEY_SECOND);
    xfer(IDX_ACCESS_KEY, 1'b1, 8'h00);
    xfer(IDX_SOFT_RESET_TRIGGER, 1'b1, TRIGGER_FIRE);
    chip_up();
    for (int i = 0; i < 7; i++)
    begin
      sel = (i > 4) ? 0 : 4 - i;
      xfer(IDX_BOOT_CONFIG, 1'b1, {1'b0, 3'(sel), 1'b0, 3'(i)});
      xfer(IDX_CLOCK_TIMING_CONTROL, 1'b1, 8'h33);
      xfer(IDX_RESET_CAUSE_STATUS, 1'b1, 8'h00);
      unlock();
      xfer(IDX_SOFT_RESET_TRIGGER, 1'b1, TRIGGER_FIRE);
      wait_up(g);
      chk(32'(g - 1), 32'(HOLD_T[i] + 1));
      rdchk(IDX_SOFT_RESET_TRIGGER, 8'h00);
      rdchk(IDX_RESET_CAUSE_STATUS, 8'h04);
      rdchk(IDX_CLOCK_TIMING_CONTROL, 8'h10);
      repeat (20) @(posedge pclk);
      gap(0, g);
      chk(32'(g), 32'(1 << sel));
    end
    for (int n = 0; n < 8; n++)
    begin
      xfer(IDX_CLOCK_TIMING_CONTROL, 1'b1, {1'b0, 3'(n), 4'h0});
      gap(1, g);
      chk(32'(g), 32'(n + 1));
    end
    port3_bit4_gpio <= 2'b10;
    repeat (3) @(posedge pclk);
    chk({30'h0, port3_bit4_pin}, 32'h2);
    port3_bit4_gpio <= 2'b01;
    repeat (3) @(posedge pclk);
    chk({30'h0, port3_bit4_pin}, 32'h1);
    for (int m = 1; m < 4; m++)
    begin
      xfer(IDX_CLOCK_TIMING_CONTROL, 1'b1, 8'h10 | 8'(m));
      gap(2, g);
      chk(32'(g), 32'(1 << (m - 1)));
    end
    for (int b = 0; b < 4; b++)
    begin
      xfer(IDX_RESET_CAUSE_STATUS, 1'b1, 8'h00);
      reset_sources <= reset_sources_t'(4'h1 << b);
      @(posedge pclk);
      reset_sources <= 4'h0;
      wait_up(g);
      rdchk(IDX_RESET_CAUSE_STATUS, 8'h1 << cause_bit[b]);
      xfer(IDX_RESET_CAUSE_STATUS, 1'b1, 8'hff);
      rdchk(IDX_RESET_CAUSE_STATUS, 8'h1 << cause_bit[b]);
    end
    xfer(IDX_EVENT_MASK, 1'b1, 8'h01);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h1);
    xfer(IDX_EVENT_MASK, 1'b1, 8'h00);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    xfer(IDX_EVENT_MASK, 1'b1, 8'h01);
    rdchk(IDX_EVENT_STATUS, 8'h07);
    xfer(IDX_EVENT_STATUS, 1'b1, 8'h07);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rdchk(IDX_EVENT_STATUS, 8'h00);
    stop_test();
  end
endmodule
